// >>> scd_regs.vh
// Register offsets, field positions, reset values and codes for the sampling clock block
`ifndef SCD_REGS_VH
`define SCD_REGS_VH

// ==========================================================
// Register offsets (15-bit serial address)
`define SCD_ADDR_CHAN_SELECT 15'h0008
`define SCD_ADDR_DIV_RATIO 15'h0108
`define SCD_ADDR_HALF_DELAY 15'h0109
`define SCD_ADDR_SYNC_STATE 15'h010b
`define SCD_ADDR_DIV_STATUS 15'h010c
`define SCD_ADDR_DELAY_CTRL 15'h0110
`define SCD_ADDR_SUPERFINE 15'h0111
`define SCD_ADDR_FINE 15'h0112
`define SCD_ADDR_DCS_A 15'h011c
`define SCD_ADDR_DCS_B 15'h011e

// ==========================================================
// Reset values
`define SCD_RST_CHAN_SELECT 8'h03
`define SCD_RST_DIV_RATIO 8'h00
`define SCD_RST_SYNC_STATE 8'h00
`define SCD_RST_LOCAL 8'h00
`define SCD_RST_DCS 8'h01

// ==========================================================
// Field positions and codes
`define SCD_DIV_BY1 2'h0
`define SCD_DIV_BY2 2'h1
`define SCD_DIV_BY4 2'h3
`define SCD_SYNC_EN_BIT 7
`define SCD_SYNC_OUT_BIT 2
`define SCD_HALF_EN_BIT 0
`define SCD_DCS_EN_BIT 0
`define SCD_MODE_OFF 3'h0
`define SCD_MODE_SF_16 3'h2
`define SCD_MODE_SF_192 3'h6
`define SCD_MODE_WIDE_BIT 2
`define SCD_FINE_MAX_16 8'h0f
`define SCD_FINE_MAX_192 8'hc0
`define SCD_SUPERFINE_MAX 8'h80

// ==========================================================
// Serial port framing
`define SCD_SPI_INSTR_BITS 5'h10
`define SCD_SPI_LAST_BIT 5'h17
`define SCD_SPI_DONE 5'h18

`endif

// >>> scd_top.v
// Sampling clock divider, phase and edge delay controls with serial register port
`timescale 1ns/1ps
`include "scd_regs.vh"

module scd_top
(
	input wire CLK_SYS,
	input wire ARST_N,
	input wire CLK_IN,
	input wire SYSREF,
	input wire SPI_SCLK,
	input wire SPI_CSB_N,
	input wire SPI_SDIO_IN,
	output reg SPI_SDIO_OUT,
	output reg SPI_SDIO_OE_N,
	output reg SAMPLE_CLK_A,
	output reg SAMPLE_CLK_B,
	output reg SAMPLE_STROBE_A,
	output reg SAMPLE_STROBE_B,
	output reg [7:0] FINE_DELAY_A,
	output reg [7:0] FINE_DELAY_B,
	output reg [7:0] SUPERFINE_DELAY_A,
	output reg [7:0] SUPERFINE_DELAY_B,
	output reg FINE_WIDE_A,
	output reg FINE_WIDE_B,
	output reg DATAPATH_RST_A,
	output reg DATAPATH_RST_B,
	output reg DUTY_CYCLE_STABILIZER_EN
);

	// ==========================================================
	// Helpers
	function [7:0] scd_clamp;
		input [7:0] val;
		input [7:0] max;
		begin
			scd_clamp = (val > max) ? max : val;
		end
	endfunction

	function scd_superfine_on;
		input [2:0] mode;
		begin
			scd_superfine_on = (mode == `SCD_MODE_SF_16) ||
				(mode == `SCD_MODE_SF_192);
		end
	endfunction

	// ==========================================================
	// Pin synchronisers
	reg [4:0] sync1;
	reg [4:0] sync2;
	reg sclk_d;
	reg clk_d;
	reg sysref_d;
	wire clk_s = sync2[0];
	wire sysref_s = sync2[1];
	wire sclk_s = sync2[2];
	wire csb_s = sync2[3];
	wire sdi_s = sync2[4];
	wire sclk_rise = sclk_s & ~sclk_d;
	wire sclk_fall = ~sclk_s & sclk_d;
	// Both input edges count: each is one half input period
	wire in_edge = clk_s ^ clk_d;
	wire sysref_rise = sysref_s & ~sysref_d;

	always @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			sync1 <= 5'h08;
			sync2 <= 5'h08;
			sclk_d <= 1'b0;
			clk_d <= 1'b0;
			sysref_d <= 1'b0;
		end
		else
		begin
			sync1 <= {SPI_SDIO_IN, SPI_CSB_N, SPI_SCLK, SYSREF, CLK_IN};
			sync2 <= sync1;
			sclk_d <= sclk_s;
			clk_d <= clk_s;
			sysref_d <= sysref_s;
		end
	end

	// ==========================================================
	// Register storage
	reg [7:0] chan_select;
	reg [7:0] div_ratio;
	reg [7:0] sync_state;
	reg [7:0] dcs_a;
	reg [7:0] dcs_b;
	reg [7:0] half_delay [0:1];
	reg [7:0] delay_ctrl [0:1];
	reg [7:0] superfine [0:1];
	reg [7:0] fine [0:1];
	reg [1:0] div_cnt;
	reg div_out;
	reg wr_stb;
	reg [14:0] wr_addr;
	reg [7:0] wr_data;
	reg [1:0] rst_pulse;
	integer i;

	// Reads show the lowest selected channel
	wire rd_ch = chan_select[0] ? 1'b0 : 1'b1;

	function [7:0] scd_read;
		input [14:0] addr;
		begin
			case (addr)
				`SCD_ADDR_CHAN_SELECT: scd_read = chan_select;
				`SCD_ADDR_DIV_RATIO: scd_read = div_ratio;
				`SCD_ADDR_HALF_DELAY: scd_read = half_delay[rd_ch];
				`SCD_ADDR_SYNC_STATE: scd_read = sync_state;
				`SCD_ADDR_DIV_STATUS: scd_read = {5'h00, div_out, div_cnt};
				`SCD_ADDR_DELAY_CTRL: scd_read = delay_ctrl[rd_ch];
				`SCD_ADDR_SUPERFINE: scd_read = superfine[rd_ch];
				`SCD_ADDR_FINE: scd_read = fine[rd_ch];
				`SCD_ADDR_DCS_A: scd_read = dcs_a;
				`SCD_ADDR_DCS_B: scd_read = dcs_b;
				default: scd_read = 8'h00;
			endcase
		end
	endfunction

	always @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			chan_select <= `SCD_RST_CHAN_SELECT;
			div_ratio <= `SCD_RST_DIV_RATIO;
			sync_state <= `SCD_RST_SYNC_STATE;
			dcs_a <= `SCD_RST_DCS;
			dcs_b <= `SCD_RST_DCS;
			rst_pulse <= 2'h0;
			for (i = 0; i < 2; i = i + 1)
			begin
				half_delay[i] <= `SCD_RST_LOCAL;
				delay_ctrl[i] <= `SCD_RST_LOCAL;
				superfine[i] <= `SCD_RST_LOCAL;
				fine[i] <= `SCD_RST_LOCAL;
			end
		end
		else
		begin
			rst_pulse <= 2'h0;
			if (wr_stb)
			begin
				case (wr_addr)
					`SCD_ADDR_CHAN_SELECT: chan_select <= {6'h00, wr_data[1:0]};
					`SCD_ADDR_DIV_RATIO: div_ratio <= wr_data;
					`SCD_ADDR_SYNC_STATE: sync_state <= wr_data;
					`SCD_ADDR_DCS_A: dcs_a <= wr_data;
					`SCD_ADDR_DCS_B: dcs_b <= wr_data;
					default: ;
				endcase
				// Local registers go to every selected channel
				for (i = 0; i < 2; i = i + 1)
				begin
					if (chan_select[i])
					begin
						case (wr_addr)
							`SCD_ADDR_HALF_DELAY: half_delay[i] <= wr_data;
							`SCD_ADDR_DELAY_CTRL:
							begin
								delay_ctrl[i] <= wr_data;
								if (wr_data[2:0] != `SCD_MODE_OFF)
									rst_pulse[i] <= 1'b1;
							end
							// No datapath reset here, link stays up
							`SCD_ADDR_SUPERFINE: superfine[i] <= wr_data;
							`SCD_ADDR_FINE: fine[i] <= wr_data;
							default: ;
						endcase
					end
				end
			end
		end
	end

	// ==========================================================
	// Serial port: 16-bit instruction (read flag, address), one data byte
	reg [4:0] bit_cnt;
	reg [15:0] instr;
	reg [7:0] wsh;
	reg [7:0] rsh;
	reg rd_op;

	always @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			bit_cnt <= 5'h00;
			instr <= 16'h0000;
			wsh <= 8'h00;
			rsh <= 8'h00;
			rd_op <= 1'b0;
			wr_stb <= 1'b0;
			wr_addr <= 15'h0000;
			wr_data <= 8'h00;
			SPI_SDIO_OUT <= 1'b0;
			SPI_SDIO_OE_N <= 1'b1;
		end
		else
		begin
			wr_stb <= 1'b0;
			if (csb_s)
			begin
				bit_cnt <= 5'h00;
				rd_op <= 1'b0;
				SPI_SDIO_OE_N <= 1'b1;
			end
			else
			begin
				if (sclk_rise && bit_cnt != `SCD_SPI_DONE)
				begin
					bit_cnt <= bit_cnt + 5'h01;
					if (bit_cnt < `SCD_SPI_INSTR_BITS)
						instr <= {instr[14:0], sdi_s};
					else
						wsh <= {wsh[6:0], sdi_s};
					if (bit_cnt == `SCD_SPI_INSTR_BITS - 5'h01)
					begin
						rd_op <= instr[14];
						rsh <= scd_read({instr[13:0], sdi_s});
					end
					if (bit_cnt == `SCD_SPI_LAST_BIT && !rd_op)
					begin
						wr_stb <= 1'b1;
						wr_addr <= instr[14:0];
						wr_data <= {wsh[6:0], sdi_s};
					end
				end
				if (sclk_fall && rd_op)
				begin
					if (bit_cnt == `SCD_SPI_DONE)
						SPI_SDIO_OE_N <= 1'b1;
					else
					begin
						SPI_SDIO_OE_N <= 1'b0;
						SPI_SDIO_OUT <= rsh[7];
						rsh <= {rsh[6:0], 1'b0};
					end
				end
			end
		end
	end

	// ==========================================================
	// Divider: toggles every N half periods, so duty is 50%
	reg [1:0] div_last;
	reg div_late;
	reg [1:0] ch_clk;

	always @*
	begin
		case (div_ratio[1:0])
			`SCD_DIV_BY2: div_last = 2'h1;
			`SCD_DIV_BY4: div_last = 2'h3;
			default: div_last = 2'h0;
		endcase
	end

	always @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			div_cnt <= 2'h0;
			div_out <= 1'b0;
			div_late <= 1'b0;
		end
		else if (sysref_rise && sync_state[`SCD_SYNC_EN_BIT])
		begin
			div_cnt <= sync_state[1:0];
			div_out <= sync_state[`SCD_SYNC_OUT_BIT];
		end
		else if (in_edge)
		begin
			div_late <= div_out;
			if (div_cnt >= div_last)
			begin
				div_cnt <= 2'h0;
				div_out <= ~div_out;
			end
			else
				div_cnt <= div_cnt + 2'h1;
		end
	end

	// ==========================================================
	// Per-channel clock, sample strobe and delay outputs
	reg [1:0] next_clk;

	// Delayed channel takes the copy one input edge late
	always @*
	begin
		next_clk[0] = half_delay[0][`SCD_HALF_EN_BIT] ? div_late : div_out;
		next_clk[1] = half_delay[1][`SCD_HALF_EN_BIT] ? div_late : div_out;
	end

	// Outputs follow the registers one cycle after the write
	always @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			ch_clk <= 2'h0;
			SAMPLE_CLK_A <= 1'b0;
			SAMPLE_CLK_B <= 1'b0;
			SAMPLE_STROBE_A <= 1'b0;
			SAMPLE_STROBE_B <= 1'b0;
			FINE_DELAY_A <= 8'h00;
			FINE_DELAY_B <= 8'h00;
			SUPERFINE_DELAY_A <= 8'h00;
			SUPERFINE_DELAY_B <= 8'h00;
			FINE_WIDE_A <= 1'b0;
			FINE_WIDE_B <= 1'b0;
			DATAPATH_RST_A <= 1'b0;
			DATAPATH_RST_B <= 1'b0;
			DUTY_CYCLE_STABILIZER_EN <= 1'b1;
		end
		else
		begin
			ch_clk <= next_clk;
			SAMPLE_CLK_A <= next_clk[0];
			SAMPLE_CLK_B <= next_clk[1];
			SAMPLE_STROBE_A <= next_clk[0] & ~ch_clk[0];
			SAMPLE_STROBE_B <= next_clk[1] & ~ch_clk[1];
			FINE_WIDE_A <= delay_ctrl[0][`SCD_MODE_WIDE_BIT];
			FINE_WIDE_B <= delay_ctrl[1][`SCD_MODE_WIDE_BIT];
			// Fine steps capped at 15 or 192 by the chosen option
			FINE_DELAY_A <= (delay_ctrl[0][2:0] == `SCD_MODE_OFF) ? 8'h00 :
				scd_clamp(fine[0], delay_ctrl[0][`SCD_MODE_WIDE_BIT] ?
				`SCD_FINE_MAX_192 : `SCD_FINE_MAX_16);
			FINE_DELAY_B <= (delay_ctrl[1][2:0] == `SCD_MODE_OFF) ? 8'h00 :
				scd_clamp(fine[1], delay_ctrl[1][`SCD_MODE_WIDE_BIT] ?
				`SCD_FINE_MAX_192 : `SCD_FINE_MAX_16);
			SUPERFINE_DELAY_A <= scd_superfine_on(delay_ctrl[0][2:0]) ?
				scd_clamp(superfine[0], `SCD_SUPERFINE_MAX) : 8'h00;
			SUPERFINE_DELAY_B <= scd_superfine_on(delay_ctrl[1][2:0]) ?
				scd_clamp(superfine[1], `SCD_SUPERFINE_MAX) : 8'h00;
			DATAPATH_RST_A <= rst_pulse[0];
			DATAPATH_RST_B <= rst_pulse[1];
			DUTY_CYCLE_STABILIZER_EN <= dcs_a[`SCD_DCS_EN_BIT] &
				dcs_b[`SCD_DCS_EN_BIT];
		end
	end

endmodule

// >>> scd_top_properties.sv
// Port properties of the sampling clock block
`timescale 1ns/1ps
module scd_top_properties
(
	input wire CLK_SYS,
	input wire ARST_N,
	input wire SPI_CSB_N,
	input wire SAMPLE_CLK_A,
	input wire SAMPLE_CLK_B,
	input wire SAMPLE_STROBE_A,
	input wire SAMPLE_STROBE_B,
	input wire [7:0] FINE_DELAY_A,
	input wire [7:0] FINE_DELAY_B,
	input wire [7:0] SUPERFINE_DELAY_A,
	input wire FINE_WIDE_A,
	input wire FINE_WIDE_B,
	input wire DATAPATH_RST_A,
	input wire DATAPATH_RST_B,
	input wire DUTY_CYCLE_STABILIZER_EN
);
	// ==========================================================
	// Properties
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!ARST_N);
	property p_strobe_a;
		$rose(SAMPLE_CLK_A) |-> SAMPLE_STROBE_A;
	endproperty
	a_strobe_a: assert property (p_strobe_a) else $error("no strobe A");
	property p_strobe_b;
		SAMPLE_STROBE_B |-> $rose(SAMPLE_CLK_B);
	endproperty
	a_strobe_b: assert property (p_strobe_b) else $error("stray strobe B");
	property p_rst_a;
		DATAPATH_RST_A |=> !DATAPATH_RST_A;
	endproperty
	a_rst_a: assert property (p_rst_a) else $error("long reset A");
	property p_rst_b;
		$rose(DATAPATH_RST_B) |=> $fell(DATAPATH_RST_B);
	endproperty
	a_rst_b: assert property (p_rst_b) else $error("long reset B");
	property p_sf_cap;
		SUPERFINE_DELAY_A <= 8'h80;
	endproperty
	a_sf_cap: assert property (p_sf_cap) else $error("superfine cap");
	property p_fine_cap;
		FINE_DELAY_A <= (FINE_WIDE_A ? 8'hc0 : 8'h0f);
	endproperty
	a_fine_cap: assert property (p_fine_cap) else $error("fine cap");
	property p_narrow;
		!FINE_WIDE_B |-> FINE_DELAY_B <= 8'h0f;
	endproperty
	a_narrow: assert property (p_narrow) else $error("narrow cap");
	property p_dcs;
		$rose(ARST_N) |-> DUTY_CYCLE_STABILIZER_EN;
	endproperty
	a_dcs: assert property (p_dcs) else $error("stabilizer off");
	property p_quiet;
		SPI_CSB_N [*8] |-> $stable(FINE_DELAY_A) && !DATAPATH_RST_A;
	endproperty
	a_quiet: assert property (p_quiet) else $error("change while idle");
	c_rst: cover property (DATAPATH_RST_A);
	c_sf: cover property (SUPERFINE_DELAY_A != 8'h00);
	c_lag: cover property ($rose(SAMPLE_CLK_A) && !SAMPLE_CLK_B);
endmodule
bind scd_top scd_top_properties i_scd_top_properties (.CLK_SYS(CLK_SYS),
	.ARST_N(ARST_N), .SPI_CSB_N(SPI_CSB_N), .SAMPLE_CLK_A(SAMPLE_CLK_A),
	.SAMPLE_CLK_B(SAMPLE_CLK_B), .SAMPLE_STROBE_A(SAMPLE_STROBE_A),
	.SAMPLE_STROBE_B(SAMPLE_STROBE_B), .FINE_DELAY_A(FINE_DELAY_A),
	.FINE_DELAY_B(FINE_DELAY_B), .SUPERFINE_DELAY_A(SUPERFINE_DELAY_A),
	.FINE_WIDE_A(FINE_WIDE_A), .FINE_WIDE_B(FINE_WIDE_B),
	.DATAPATH_RST_A(DATAPATH_RST_A), .DATAPATH_RST_B(DATAPATH_RST_B),
	.DUTY_CYCLE_STABILIZER_EN(DUTY_CYCLE_STABILIZER_EN));

// >>> scd_host_model.sv
// Clock source and serial host model for the sampling clock block
`timescale 1ns/1ps
module scd_host_model
(
	input wire clk,
	input wire sdio_out,
	input wire sdio_oe_n,
	output reg clk_in,
	output reg sysref,
	output reg sclk,
	output reg csb_n,
	output wire sdio_in
);
	reg run;
	reg drv;
	reg [1:0] n;
	// ==========================================================
	// Pins; a released line shows the inverse of its last level
	assign sdio_in = sdio_oe_n ? drv : sdio_out;
	initial
	begin
		{clk_in, sysref, sclk, run, drv, n} = 7'h00;
		csb_n = 1'b1;
	end
	// Starts only once the bench has set the ratio
	always @(posedge clk)
	begin
		n <= #5 run ? n + 2'h1 : 2'h0;
		if (run && n == 2'h3)
			clk_in <= #5 ~clk_in;
	end
	task cyc(input integer k);
		begin
			repeat (k) @(posedge clk);
			#5;
		end
	endtask
	// Levels of 4 cycles, well above the 3-cycle minimum
	task xfer(input [23:0] f, output [7:0] rd);
		integer i;
		begin
			rd = 8'h00;
			csb_n = 1'b0;
			for (i = 23; i >= 0; i = i - 1)
			begin
				drv = (f[23] && i < 8) ? ~drv : f[i];
				cyc(4);
				sclk = 1'b1;
				cyc(4);
				if (i < 8)
					rd[i] = sdio_in;
				sclk = 1'b0;
			end
			cyc(8);
			csb_n = 1'b1;
			drv = ~drv;
			cyc(4);
		end
	endtask
	task sync_pulse;
		begin
			sysref = 1'b1;
			cyc(4);
			sysref = 1'b0;
			cyc(8);
		end
	endtask
endmodule

// >>> scd_top_tb_top.sv
// Self-checking bench for the sampling clock block
`timescale 1ns/1ps
`include "scd_regs.vh"
module scd_top_tb_top;
	reg clk = 1'b0;
	reg rst_n = 1'b0;
	wire ci, sr, sck, cs, sdi, sdo, oe, ca, cb, sa, sb, wa, wb, ra, rb, duty_cycle_stabilizer;
	wire [7:0] fa, fb, xa, xb;
	integer errors = 0;
	integer checks_done = 0;
	integer pulses = 0;
	integer i;
	integer t;
	reg [7:0] v;
	reg [7:0] m;
	reg [7:0] d;
	always #25 clk = ~clk;
	always @(posedge clk)
		pulses <= pulses + ra + rb;
	scd_host_model i_scd_host_model (.clk(clk), .sdio_out(sdo),
		.sdio_oe_n(oe), .clk_in(ci), .sysref(sr), .sclk(sck), .csb_n(cs),
		.sdio_in(sdi));
	scd_top i_scd_top (.CLK_SYS(clk), .ARST_N(rst_n), .CLK_IN(ci),
		.SYSREF(sr), .SPI_SCLK(sck), .SPI_CSB_N(cs), .SPI_SDIO_IN(sdi),
		.SPI_SDIO_OUT(sdo), .SPI_SDIO_OE_N(oe), .SAMPLE_CLK_A(ca),
		.SAMPLE_CLK_B(cb), .SAMPLE_STROBE_A(sa), .SAMPLE_STROBE_B(sb),
		.FINE_DELAY_A(fa), .FINE_DELAY_B(fb), .SUPERFINE_DELAY_A(xa),
		.SUPERFINE_DELAY_B(xb), .FINE_WIDE_A(wa), .FINE_WIDE_B(wb),
		.DATAPATH_RST_A(ra), .DATAPATH_RST_B(rb),
		.DUTY_CYCLE_STABILIZER_EN(duty_cycle_stabilizer));
	// ==========================================================
	// Tasks
	task chk(input [79:0] nm, input [7:0] e, input [7:0] g);
		begin
			checks_done = checks_done + 1;
			if (g !== e)
			begin
				errors = errors + 1;
				$display("[FAIL] %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task wr(input [14:0] a, input [7:0] w);
		i_scd_host_model.xfer({1'b0, a, w}, v);
	endtask
	task rd(input [14:0] a, input [7:0] e, input [79:0] nm);
		begin
			i_scd_host_model.xfer({1'b1, a, 8'h00}, v);
			chk(nm, e, v);
		end
	endtask
	// Window of 64 cycles spans whole periods for every ratio
	task meas;
		begin
			{v, m, d} = 24'h000000;
			t = 0;
			repeat (64)
			begin
				i_scd_host_model.cyc(1);
				v = v + ca;
				m = m + sa;
				t = t + sb;
				d = d + (ca ^ cb);
			end
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d mismatches %0d", checks_done, errors);
			if (errors == 0 && checks_done > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	initial
	begin
		#2000000;
		errors = errors + 1;
		finish_test;
	end
	initial
	begin
		i_scd_host_model.cyc(2);
		rst_n = 1'b1;
		i_scd_host_model.cyc(4);
		chk("dcs_en", 8'h01, {7'h0, duty_cycle_stabilizer});
		rd(`SCD_ADDR_DCS_A, 8'h01, "dcs_a");
		rd(`SCD_ADDR_DIV_RATIO, 8'h00, "ratio");
		rd(15'h0200, 8'h00, "unmapped");
		wr(`SCD_ADDR_DCS_B, 8'h00);
		chk("dcs_off", 8'h00, {7'h0, duty_cycle_stabilizer});
		wr(`SCD_ADDR_DCS_B, 8'h01);
		$display("reset test done");
		for (i = 0; i < 3; i = i + 1)
		begin
			wr(`SCD_ADDR_DIV_RATIO, (8'h01 << i) - 8'h01);
			i_scd_host_model.run = 1'b1;
			i_scd_host_model.cyc(40);
			meas;
			chk("high", 8'h20, v);
			chk("rises", 8'h08 >> i, m);
			chk("rises_b", 8'h08 >> i, t[7:0]);
			chk("skew", 8'h00, d);
		end
		wr(`SCD_ADDR_CHAN_SELECT, 8'h02);
		wr(`SCD_ADDR_HALF_DELAY, 8'h01);
		wr(`SCD_ADDR_DIV_RATIO, 8'h01);
		wr(`SCD_ADDR_CHAN_SELECT, 8'h03);
		i_scd_host_model.cyc(40);
		meas;
		chk("lag", 8'h20, d);
		chk("lag_rises", 8'h04, t[7:0]);
		chk("no_rst", 8'h00, pulses[7:0]);
		$display("divider test done");
		wr(`SCD_ADDR_FINE, 8'hff);
		wr(`SCD_ADDR_SUPERFINE, 8'hff);
		chk("amounts", 8'h00, pulses[7:0]);
		for (i = 0; i < 8; i = i + 1)
		begin
			t = pulses;
			wr(`SCD_ADDR_DELAY_CTRL, i[7:0]);
			chk("fine", i == 0 ? 8'h00 : i > 3 ? 8'hc0 : 8'h0f, fb);
			chk("sf", (i == 2 || i == 6) ? 8'h80 : 8'h00, xa);
			chk("wide", {7'h0, i[2]}, {7'h0, wa});
			chk("wide_b", {7'h0, i[2]}, {7'h0, wb});
			chk("sf_b", (i == 2 || i == 6) ? 8'h80 : 8'h00, xb);
			chk("rst", i == 0 ? 8'h00 : 8'h02, 8'(pulses - t));
		end
		wr(`SCD_ADDR_CHAN_SELECT, 8'h01);
		wr(`SCD_ADDR_FINE, 8'h05);
		chk("fine_a", 8'h05, fa);
		chk("fine_b", 8'hc0, fb);
		wr(`SCD_ADDR_CHAN_SELECT, 8'h03);
		rd(`SCD_ADDR_FINE, 8'h05, "fine_rd");
		$display("delay test done");
		i_scd_host_model.run = 1'b0;
		for (i = 0; i < 2; i = i + 1)
		begin
			d = i == 0 ? 8'h84 : 8'h81;
			wr(`SCD_ADDR_SYNC_STATE, d);
			i_scd_host_model.sync_pulse;
			rd(`SCD_ADDR_DIV_STATUS, d & 8'h07, "div_state");
			chk("clk_a", {7'h0, d[2]}, {7'h0, ca});
		end
		$display("sync test done");
		finish_test;
	end
endmodule
